// File: rtl/odc_pkg.sv
// Shared constants and carrier types for the channel one output and
// divider control bank.
// Assumes a single clock domain and AXI4-Lite with 32-bit data.
package odc_pkg;

	// Register indices; byte address is four times the index
	localparam logic [13:0] ODC_IDX_FIRST_PAIR = 14'h2202;
	localparam logic [13:0] ODC_IDX_SECOND_PAIR = 14'h2203;
	localparam logic [13:0] ODC_IDX_PLL_MODE = 14'h2205;
	localparam logic [13:0] ODC_IDX_OUT_MODE = 14'h2210;
	localparam logic [13:0] ODC_IDX_STATUS = 14'h2211;

	// Field positions inside the PLL mode register
	localparam int ODC_PLL_STEP_EN_BIT = 7;
	localparam int ODC_PLL_ASSIGN_LSB = 4;
	localparam int ODC_PLL_SEL_LSB = 2;

	// Reset values of the writable registers
	localparam logic [5:0] ODC_PAIR_RESET = 6'h00;
	localparam logic [5:0] ODC_PLL_RESET = 6'h00;
	localparam logic [1:0] ODC_MODE_RESET = 2'h0;

	// Highest legal translation profile code
	localparam logic [2:0] ODC_PROFILE_LAST = 3'h5;

	// Profile selection mode codes
	localparam logic [1:0] ODC_SEL_AUTO = 2'h0;
	localparam logic [1:0] ODC_SEL_MAN_AUTO = 2'h1;
	localparam logic [1:0] ODC_SEL_MAN_HOLD = 2'h2;
	localparam logic [1:0] ODC_SEL_USER = 2'h3;

	// AXI response codes
	localparam logic [1:0] ODC_RESP_OKAY = 2'h0;
	localparam logic [1:0] ODC_RESP_SLVERR = 2'h2;

	// Output pair control bits, bit 5 down to bit 0
	typedef struct packed {
		logic drv_reset;
		logic power_down;
		logic mute_neg;
		logic mute_pos;
		logic rst_neg_div;
		logic rst_pos_div;
	} odc_pair_ctrl_t;

	// One output pair at the pins; oe_n low while driving
	typedef struct packed {
		logic pos;
		logic neg;
		logic oe_n;
	} odc_pins_t;

	// PLL mode control bits held by the bank
	typedef struct packed {
		logic step_fault_en;
		logic [2:0] assign_profile;
		logic [1:0] sel_mode;
	} odc_pll_ctrl_t;

	// PLL control status and strobes
	typedef struct packed {
		logic discard_edge;
		logic acquire_start;
		logic monitor_reset;
		logic holdover_req;
		logic fallback;
		logic waiting;
		logic [2:0] profile;
	} odc_pll_stat_t;

endpackage

// File: rtl/odc_pair_driver.sv
// One output pair: two distribution dividers and their drivers.
// Assumes control bits arrive from registers on the same clock.
`timescale 1ns/100ps
module odc_pair_driver import odc_pkg::*; (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire odc_pair_ctrl_t i_ctrl,
	input wire logic i_diff,
	output odc_pins_t o_pins
);

	// Whole state of the pair
	typedef struct packed {
		logic div_pos;
		logic div_neg;
		logic mute_pos;
		logic mute_neg;
		logic hold;
		odc_pins_t pins;
	} odc_drv_state_t;

	odc_drv_state_t st; // Registered state
	odc_drv_state_t next_st; // Next state
	logic release_ok; // Positive leg is low now
	logic pos_live; // Positive leg level to be shown

	// Dividers toggle each cycle; mutes and the hold release move only while a leg is low,
	// so a mute or release never cuts a high pulse short or starts one late
	always_comb begin
		next_st = st;
		// Restart on a low positive leg only: waiting for both legs
		// could stall for ever when the two dividers run out of phase
		release_ok = !st.div_pos;
		// Divider reset clears at once and holds while set
		next_st.div_pos = i_ctrl.rst_pos_div ? 1'b0 : ~st.div_pos; // (R4) (R11)
		next_st.div_neg = i_ctrl.rst_neg_div ? 1'b0 : ~st.div_neg; // (R3) (R10)
		if (!st.div_pos) begin
			next_st.mute_pos = i_ctrl.mute_pos; // (R2)
		end
		if (!st.div_neg) begin
			// Negative mute is meaningless in differential mode
			next_st.mute_neg = i_ctrl.mute_neg && !i_diff; // (R2) (R8)
		end
		if (i_ctrl.drv_reset) begin
			next_st.hold = 1'b1; // (R5)
		end else if (release_ok) begin
			next_st.hold = 1'b0; // (R6)
		end
		pos_live = next_st.div_pos && !next_st.mute_pos && !next_st.hold; // (R1) (R9)
		next_st.pins.pos = pos_live;
		next_st.pins.oe_n = 1'b0;
		if (i_diff) begin
			// Complement is high whenever positive is held low
			next_st.pins.neg = !pos_live; // (R1) (R5) (R9)
		end else begin
			// Driver reset holds the complement high in either mode
			next_st.pins.neg = next_st.hold || (next_st.div_neg &&
				!next_st.mute_neg); // (R5) (R8)
		end
		if (i_ctrl.power_down) begin
			// Powered down wins over mute and reset
			next_st.pins = '{pos: 1'b0, neg: 1'b0, oe_n: 1'b1}; // (R7)
		end
	end

	// State register
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign o_pins = st.pins;

endmodule

// File: rtl/odc_pll_ctrl.sv
// Phase step fault response and translation profile choice.
// Assumes PLL side inputs are logic on the same clock.
`timescale 1ns/100ps
module odc_pll_ctrl import odc_pkg::*; (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire odc_pll_ctrl_t i_ctrl,
	input wire logic i_phase_step,
	input wire logic i_ref_valid,
	input wire logic i_profile_invalid,
	input wire logic [2:0] i_auto_profile,
	output odc_pll_stat_t o_stat
);

	// Step fault sequence
	typedef enum logic [1:0] {RUN, MON_RESET, WAIT_VALID} odc_step_t;

	typedef struct packed {
		odc_step_t step;
		odc_pll_stat_t stat;
	} odc_pll_state_t;

	odc_pll_state_t st; // Registered state
	odc_pll_state_t next_st; // Next state
	logic manual; // Manual profile modes only

	// Sequence and profile choice
	always_comb begin
		next_st = st;
		next_st.stat.discard_edge = 1'b0;
		next_st.stat.acquire_start = 1'b0;
		next_st.stat.monitor_reset = 1'b0;
		manual = (i_ctrl.sel_mode == ODC_SEL_MAN_AUTO) ||
			(i_ctrl.sel_mode == ODC_SEL_MAN_HOLD); // (R17)
		if (i_phase_step) begin
			next_st.stat.discard_edge = 1'b1; // (R13)
			if (i_ctrl.step_fault_en) begin
				next_st.stat.monitor_reset = 1'b1; // (R14)
				next_st.step = MON_RESET;
			end else begin
				next_st.stat.acquire_start = 1'b1; // (R13)
				next_st.step = RUN;
			end
		end else begin
			case (st.step)
				RUN: begin
				end
				// One idle cycle so a stale valid is not taken
				MON_RESET: begin
					next_st.step = WAIT_VALID;
				end
				WAIT_VALID: begin
					if (i_ref_valid) begin
						next_st.stat.acquire_start = 1'b1; // (R14)
						next_st.step = RUN;
					end
				end
				default: begin
					next_st.step = RUN;
				end
			endcase
		end
		next_st.stat.waiting = (next_st.step != RUN);
		// Fallback latches until software leaves the manual modes
		if (!manual) begin
			next_st.stat.fallback = 1'b0;
		end else if (i_profile_invalid) begin
			next_st.stat.fallback = 1'b1; // (R17)
		end
		if (manual && !next_st.stat.fallback) begin
			next_st.stat.profile = i_ctrl.assign_profile; // (R15)
		end else begin
			next_st.stat.profile = i_auto_profile; // (R15) (R17)
		end
		next_st.stat.holdover_req = next_st.stat.fallback &&
			(i_ctrl.sel_mode == ODC_SEL_MAN_HOLD); // (R17)
	end

	// State register
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			st <= '{step: RUN, stat: '0};
		end else begin
			st <= next_st;
		end
	end

	assign o_stat = st.stat;

endmodule

// File: rtl/odc_bank.sv
// Register bank for the channel one output pairs and PLL mode bits,
// reached over AXI4-Lite, with the pair drivers and PLL control.
// Assumes one 25 MHz clock and PLL side signals on that clock.
//
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/100ps

// Function
// (R1) First pair positive mute: low, complement high
// (R2) Mute entry and exit never emit runts
// (R3) First pair negative divider reset is immediate
// (R4) First pair positive divider reset is immediate
// (R5) Second pair driver reset: low/high at once
// (R6) Driver reset release emits no runt
// (R7) Second pair power down tristates both drivers
// (R8) Second pair negative mute, ignored when differential
// (R9) Second pair positive mute: low, complement high
// (R10) Second pair negative divider reset is immediate
// (R11) Second pair positive divider reset is immediate
// (R12) Software uses power down for high impedance
// (R13) Step fault: discard edge, reacquire
// (R14) Step fault enabled: reset monitor, await validation
// (R15) Assign field picks profile in manual modes
// (R16) Profile codes 110 and 111 are refused
// (R17) Manual modes fall back to priority or holdover
// (R18) All control bits clear at reset
module odc_bank import odc_pkg::*; (
	input wire logic I_CLK,
	input wire logic I_RST,
	// AXI4-Lite write address channel
	input wire logic I_AWVALID,
	output logic O_AWREADY,
	input wire logic [15:0] I_AWADDR,
	// AXI4-Lite write data channel
	input wire logic I_WVALID,
	output logic O_WREADY,
	input wire logic [31:0] I_WDATA,
	input wire logic [3:0] I_WSTRB,
	// AXI4-Lite write response channel
	output logic O_BVALID,
	input wire logic I_BREADY,
	output logic [1:0] O_BRESP,
	// AXI4-Lite read address channel
	input wire logic I_ARVALID,
	output logic O_ARREADY,
	input wire logic [15:0] I_ARADDR,
	// AXI4-Lite read data channel
	output logic O_RVALID,
	input wire logic I_RREADY,
	output logic [31:0] O_RDATA,
	output logic [1:0] O_RRESP,
	// PLL side, same clock
	input wire logic I_PHASE_STEP,
	input wire logic I_REF_VALID,
	input wire logic I_PROFILE_INVALID,
	input wire logic [2:0] I_AUTO_PROFILE,
	output logic O_DISCARD_EDGE,
	output logic O_ACQUIRE_START,
	output logic O_MONITOR_RESET,
	output logic O_HOLDOVER_REQ,
	output logic [2:0] O_ACTIVE_PROFILE,
	// First output pair pins
	output logic O_FIRST_PAIR_POSITIVE_PIN,
	output logic O_FIRST_PAIR_NEGATIVE_PIN,
	output logic O_FIRST_PAIR_OE_N,
	// Second output pair pins
	output logic O_SECOND_PAIR_POSITIVE_PIN,
	output logic O_SECOND_PAIR_NEGATIVE_PIN,
	output logic O_SECOND_PAIR_OE_N
);

	// Whole state of the bank. Bus handshake flags, the held write
	// halves and the control registers live in one packed word, so a
	// single register process updates everything and reset has one
	// image to load.
	typedef struct packed {
		logic awready;
		logic aw_held;
		logic [13:0] aw_idx;
		logic wready;
		logic w_held;
		logic [7:0] wdata;
		logic wstrb0;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [7:0] rdata;
		logic [1:0] rresp;
		odc_pair_ctrl_t first_pair;
		odc_pair_ctrl_t second_pair;
		odc_pll_ctrl_t pll;
		logic [1:0] out_mode;
	} odc_bank_state_t;

	// Reset image; every control bit starts at zero
	localparam odc_bank_state_t RESET_STATE = '{
		first_pair: ODC_PAIR_RESET,
		second_pair: ODC_PAIR_RESET,
		pll: ODC_PLL_RESET,
		out_mode: ODC_MODE_RESET,
		default: '0
	};

	odc_bank_state_t st; // Registered state
	odc_bank_state_t next_st; // Next state
	odc_pll_stat_t pll_stat; // Status from the PLL control
	odc_pins_t first_pins; // First pair pin levels
	odc_pins_t second_pins; // Second pair pin levels
	logic [13:0] rd_idx; // Word index of the read request
	logic [2:0] wr_profile; // Profile code carried by a write

	// Bus transactions and register updates.
	// A write is committed one cycle after both halves are held. This
	// costs a cycle of latency but keeps the decode off the input pins,
	// and it lets address and data arrive in either order.
	// Reads and writes run independently; a read of a register that is
	// being written in the same cycle returns the old value.
	always_comb begin
		next_st = st;
		rd_idx = I_ARADDR[15:2];
		wr_profile = st.wdata[ODC_PLL_ASSIGN_LSB +: 3];

		// Address and data are taken in either order and held
		if (I_AWVALID && st.awready) begin
			next_st.aw_held = 1'b1;
			next_st.aw_idx = I_AWADDR[15:2];
		end
		if (I_WVALID && st.wready) begin
			next_st.w_held = 1'b1;
			// Registers are eight bits, so only lane zero matters
			next_st.wdata = I_WDATA[7:0];
			next_st.wstrb0 = I_WSTRB[0];
		end

		// Response leaves once the master takes it
		if (st.bvalid && I_BREADY) begin
			next_st.bvalid = 1'b0;
		end

		// Both halves present: perform the write and answer
		if (st.aw_held && st.w_held && !st.bvalid) begin
			next_st.aw_held = 1'b0;
			next_st.w_held = 1'b0;
			next_st.bvalid = 1'b1;
			next_st.bresp = ODC_RESP_OKAY;
			case (st.aw_idx)
				ODC_IDX_FIRST_PAIR: begin
					// Reserved upper bits are not stored
					if (st.wstrb0) begin
						next_st.first_pair = st.wdata[5:0];
					end
				end
				ODC_IDX_SECOND_PAIR: begin
					if (st.wstrb0) begin
						next_st.second_pair = st.wdata[5:0];
					end
				end
				ODC_IDX_PLL_MODE: begin
					if (st.wstrb0) begin
						next_st.pll.step_fault_en =
							st.wdata[ODC_PLL_STEP_EN_BIT];
						next_st.pll.sel_mode =
							st.wdata[ODC_PLL_SEL_LSB +: 2];
						// Unused codes keep the last legal profile
						if (wr_profile <= ODC_PROFILE_LAST) begin
							next_st.pll.assign_profile = wr_profile; // (R16)
						end
					end
				end
				ODC_IDX_OUT_MODE: begin
					if (st.wstrb0) begin
						next_st.out_mode = st.wdata[1:0];
					end
				end
				ODC_IDX_STATUS: begin
					// Status is read only; the write is dropped
				end
				default: begin
					next_st.bresp = ODC_RESP_SLVERR;
				end
			endcase
		end

		// One write at a time: no new halves while an answer waits.
		// The readies rise again at the edge that takes the response,
		// so back-to-back writes lose no extra cycle.
		next_st.awready = !next_st.aw_held && !next_st.bvalid;
		next_st.wready = !next_st.w_held && !next_st.bvalid;

		// Read data leaves once the master takes it
		if (st.rvalid && I_RREADY) begin
			next_st.rvalid = 1'b0;
		end

		// Read request answered on the following cycle. Data is
		// captured at the taking edge and held until the master takes
		// it, so a slow master still sees one consistent value.
		if (I_ARVALID && st.arready) begin
			next_st.rvalid = 1'b1;
			next_st.rresp = ODC_RESP_OKAY;
			next_st.rdata = 8'h00;
			case (rd_idx)
				ODC_IDX_FIRST_PAIR: begin
					// Reserved bits read as zero
					next_st.rdata = {2'h0, st.first_pair};
				end
				ODC_IDX_SECOND_PAIR: begin
					next_st.rdata = {2'h0, st.second_pair};
				end
				ODC_IDX_PLL_MODE: begin
					next_st.rdata = {st.pll, 2'h0};
				end
				ODC_IDX_OUT_MODE: begin
					next_st.rdata = {6'h00, st.out_mode};
				end
				ODC_IDX_STATUS: begin
					// Live state of the PLL control; the strobes are not
					// shown, they last one cycle and software would miss
					// them
					next_st.rdata = {2'h0, pll_stat.fallback,
						pll_stat.waiting, pll_stat.holdover_req,
						pll_stat.profile};
				end
				default: begin
					next_st.rresp = ODC_RESP_SLVERR;
				end
			endcase
		end

		// One read at a time
		next_st.arready = !next_st.rvalid;
	end

	// State register; reset clears every control bit, so all outputs
	// come up unmuted, powered and out of reset
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			st <= RESET_STATE; // (R18)
		end else begin
			st <= next_st;
		end
	end

	// The pair drivers see the control bits one cycle after the write
	// commits, so a divider reset or mute takes hold two edges after the
	// write handshake. Each driver does its own runt gating.
	// First pair; mode bit zero selects differential
	odc_pair_driver u_first_pair (
		.i_clk(I_CLK),
		.i_rst(I_RST),
		.i_ctrl(st.first_pair),
		.i_diff(st.out_mode[0]),
		.o_pins(first_pins)
	);

	// Second pair; mode bit one selects differential
	odc_pair_driver u_second_pair (
		.i_clk(I_CLK),
		.i_rst(I_RST),
		.i_ctrl(st.second_pair),
		.i_diff(st.out_mode[1]),
		.o_pins(second_pins)
	);

	// Step fault response and profile choice
	odc_pll_ctrl u_pll_ctrl (
		.i_clk(I_CLK),
		.i_rst(I_RST),
		.i_ctrl(st.pll),
		.i_phase_step(I_PHASE_STEP),
		.i_ref_valid(I_REF_VALID),
		.i_profile_invalid(I_PROFILE_INVALID),
		.i_auto_profile(I_AUTO_PROFILE),
		.o_stat(pll_stat)
	);

	// Bus outputs straight from the state register
	assign O_AWREADY = st.awready;
	assign O_WREADY = st.wready;
	assign O_BVALID = st.bvalid;
	assign O_BRESP = st.bresp;
	assign O_ARREADY = st.arready;
	assign O_RVALID = st.rvalid;
	// Upper bytes are constant zero
	assign O_RDATA = {24'h000000, st.rdata};
	assign O_RRESP = st.rresp;

	// PLL strobes and status, registered inside the controller.
	// The strobes last one cycle; the PLL core must sample them on
	// every edge of this clock.
	assign O_DISCARD_EDGE = pll_stat.discard_edge;
	assign O_ACQUIRE_START = pll_stat.acquire_start;
	assign O_MONITOR_RESET = pll_stat.monitor_reset;
	assign O_HOLDOVER_REQ = pll_stat.holdover_req;
	assign O_ACTIVE_PROFILE = pll_stat.profile;

	// Pins, registered inside the pair drivers
	assign O_FIRST_PAIR_POSITIVE_PIN = first_pins.pos;
	assign O_FIRST_PAIR_NEGATIVE_PIN = first_pins.neg;
	assign O_FIRST_PAIR_OE_N = first_pins.oe_n;
	assign O_SECOND_PAIR_POSITIVE_PIN = second_pins.pos;
	assign O_SECOND_PAIR_NEGATIVE_PIN = second_pins.neg;
	assign O_SECOND_PAIR_OE_N = second_pins.oe_n;

endmodule

// File: verif/odc_bank_props.sv
// Concurrent checks on the ports of the output and divider control bank.
// Assumes it is bound to odc_bank and sees only that module's ports.
`timescale 1ns/100ps
module odc_bank_props (
	input wire logic I_CLK,
	input wire logic I_RST,
	input wire logic I_AWVALID,
	input wire logic O_AWREADY,
	input wire logic [15:0] I_AWADDR,
	input wire logic I_WVALID,
	input wire logic O_WREADY,
	input wire logic [31:0] I_WDATA,
	input wire logic [3:0] I_WSTRB,
	input wire logic I_PHASE_STEP,
	input wire logic [2:0] I_AUTO_PROFILE,
	input wire logic O_DISCARD_EDGE,
	input wire logic O_ACQUIRE_START,
	input wire logic O_MONITOR_RESET,
	input wire logic [2:0] O_ACTIVE_PROFILE,
	input wire logic O_FIRST_PAIR_OE_N,
	input wire logic O_SECOND_PAIR_POSITIVE_PIN,
	input wire logic O_SECOND_PAIR_NEGATIVE_PIN,
	input wire logic O_SECOND_PAIR_OE_N
);
	// Second pair write with both halves taken at one edge, lane 0 on
	wire logic sp_wr = I_AWVALID && O_AWREADY && I_WVALID && O_WREADY &&
		I_WSTRB[0] && I_AWADDR == 16'h880c;
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (I_RST);
	property p_step; I_PHASE_STEP |-> ##[1:2] O_DISCARD_EDGE; endproperty
	a_step: assert property (p_step) else $error("step not discarded");
	property p_ack;
		O_DISCARD_EDGE |-> O_ACQUIRE_START || O_MONITOR_RESET;
	endproperty
	a_ack: assert property (p_ack) else $error("step without response");
	property p_idle; O_MONITOR_RESET |=> !O_ACQUIRE_START; endproperty
	a_idle: assert property (p_idle) else $error("acquire too early");
	property p_pd_static;
		O_SECOND_PAIR_OE_N |-> !O_SECOND_PAIR_POSITIVE_PIN &&
			!O_SECOND_PAIR_NEGATIVE_PIN;
	endproperty
	a_pd_static: assert property (p_pd_static) else $error("pd pins");
	property p_pd_write;
		sp_wr && I_WDATA[4] |-> ##[1:3] O_SECOND_PAIR_OE_N;
	endproperty
	a_pd_write: assert property (p_pd_write) else $error("no tristate");
	property p_drv_reset;
		sp_wr && I_WDATA[5:4] == 2'h2 |->
			##[1:4] (!O_SECOND_PAIR_POSITIVE_PIN &&
			O_SECOND_PAIR_NEGATIVE_PIN) [*4];
	endproperty
	a_drv_reset: assert property (p_drv_reset) else $error("drv reset");
	property p_div_reset;
		sp_wr && !I_WDATA[4] && I_WDATA[0] |->
			##[1:5] (!O_SECOND_PAIR_POSITIVE_PIN) [*4];
	endproperty
	a_div_reset: assert property (p_div_reset) else $error("div reset");
	property p_reset_clear;
		$fell(I_RST) |-> !O_FIRST_PAIR_OE_N && !O_SECOND_PAIR_OE_N;
	endproperty
	a_reset_clear: assert property (p_reset_clear) else $error("oe reset");
	// Only a passed-through automatic choice may show a code above five
	property p_legal;
		O_ACTIVE_PROFILE > 3'h5 |-> $past(I_AUTO_PROFILE) > 3'h5 ||
			$past(I_AUTO_PROFILE, 2) > 3'h5;
	endproperty
	a_legal: assert property (p_legal) else $error("illegal profile");
endmodule

bind odc_bank odc_bank_props u_props (.*);

// File: verif/odc_clock_load.sv
// Model of a clock load on one output pin: counts edges, flags runts.
// Assumes pins change only on the bank clock, so any pulse shorter
// than one 40 ns cycle is a runt.
`timescale 1ns/100ps
module odc_clock_load (
	input wire logic i_pin,
	input wire logic i_oe_n,
	output logic [7:0] o_edges,
	output logic o_level,
	output logic [7:0] o_runts
);
	realtime last_edge;
	// Termination pulls a tristated pin low
	assign o_level = i_oe_n ? 1'h0 : i_pin;
	initial begin
		o_edges = 8'h00;
		o_runts = 8'h00;
		last_edge = -100.0;
	end
	// Every level change is an edge; a short gap since the last is a runt
	always @(o_level) begin
		if ($realtime - last_edge < 40.0) begin
			o_runts = o_runts + 8'h01;
		end
		last_edge = $realtime;
		o_edges = o_edges + 8'h01;
	end
endmodule

// File: verif/tb.sv
// Self-checking bench for the output and divider control bank.
// Assumes odc_bank, its package, the checker and the load model.
`timescale 1ns/100ps
module tb;
	logic clk = 0, rst = 1, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
	logic [15:0] awa = 0, ara = 0;
	logic [31:0] wd = 0;
	logic stp = 0, rv = 0, inv = 0;
	logic [2:0] auto = 0;
	logic awr, wr_rdy, bv, arr, rvl, dsc, acq, mon, hold;
	logic [1:0] bresp, rresp;
	logic [31:0] rdat;
	logic [2:0] prof;
	logic [3:0] pw;
	logic f_oe, s_oe;
	logic [7:0] ed [4];
	logic [7:0] rn [4];
	logic lv [4];
	int checks = 0, fail_count = 0, cyc = 0, k;
	logic [15:0] pa [15] = '{16'h880c, 16'h880c, 16'h880c, 16'h880c,
		16'h880c, 16'h880c, 16'h8840, 16'h880c, 16'h880c, 16'h880c,
		16'h8808, 16'h8808, 16'h8840, 16'h8808, 16'h880c};
	logic [7:0] pd [15] = '{8'h04, 8'h08, 8'h01, 8'h02, 8'h20, 8'h10, 8'h03,
		8'h08, 8'h04, 8'h20, 8'h04, 8'h01, 8'h00, 8'h02, 8'h00};
	// Per pin 10 toggling, 00 static low, 01 static high; then second oe_n
	logic [8:0] pe [15] = '{9'h144, 9'h150, 9'h144, 9'h150, 9'h142,
		9'h141, 9'h141, 9'h154, 9'h142, 9'h142, 9'h022, 9'h022, 9'h042,
		9'h102, 9'h114};
	initial forever #20 clk = ~clk;
	odc_bank dut (.I_CLK(clk), .I_RST(rst), .I_AWVALID(awv),
		.O_AWREADY(awr), .I_AWADDR(awa), .I_WVALID(wv), .O_WREADY(wr_rdy),
		.I_WDATA(wd), .I_WSTRB(4'h1), .O_BVALID(bv), .I_BREADY(br),
		.O_BRESP(bresp), .I_ARVALID(arv), .O_ARREADY(arr), .I_ARADDR(ara),
		.O_RVALID(rvl), .I_RREADY(rr), .O_RDATA(rdat), .O_RRESP(rresp),
		.I_PHASE_STEP(stp), .I_REF_VALID(rv), .I_PROFILE_INVALID(inv),
		.I_AUTO_PROFILE(auto), .O_DISCARD_EDGE(dsc), .O_ACQUIRE_START(acq),
		.O_MONITOR_RESET(mon), .O_HOLDOVER_REQ(hold),
		.O_ACTIVE_PROFILE(prof), .O_FIRST_PAIR_POSITIVE_PIN(pw[3]),
		.O_FIRST_PAIR_NEGATIVE_PIN(pw[2]), .O_FIRST_PAIR_OE_N(f_oe),
		.O_SECOND_PAIR_POSITIVE_PIN(pw[1]),
		.O_SECOND_PAIR_NEGATIVE_PIN(pw[0]), .O_SECOND_PAIR_OE_N(s_oe));
	// One load per pin, first pair positive first
	for (genvar i = 0; i < 4; i++) begin : g_load
		odc_clock_load u_load (.i_pin(pw[3 - i]), .i_oe_n(i < 2 ? f_oe : s_oe),
			.o_edges(ed[i]), .o_level(lv[i]), .o_runts(rn[i]));
	end
	task automatic end_sim;
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Hang guard: the whole sequence needs well under this many cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			end_sim;
		end
	end
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	// Address and data offered together; readies sampled mid-cycle
	task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic [1:0] r);
		logic ad, dd, ha, hw;
		ad = 0;
		dd = 0;
		@(posedge clk);
		awa <= a; wd <= {24'h0, d}; awv <= 1; wv <= 1; br <= 1;
		while (!(ad && dd)) begin
			@(negedge clk);
			ha = !ad && awr === 1'h1;
			hw = !dd && wr_rdy === 1'h1;
			@(posedge clk);
			if (ha) begin awv <= 0; ad = 1; end
			if (hw) begin wv <= 0; dd = 1; end
		end
		do @(negedge clk); while (bv !== 1'h1);
		chk("bresp", 32'(r), 32'(bresp));
		@(posedge clk);
		br <= 0;
	endtask
	task automatic rd(input logic [15:0] a, input logic [7:0] d, input logic [1:0] r);
		@(posedge clk);
		ara <= a; arv <= 1; rr <= 1;
		do @(negedge clk); while (arr !== 1'h1);
		@(posedge clk);
		arv <= 0;
		do @(negedge clk); while (rvl !== 1'h1);
		chk("rdata", {24'h0, d}, rdat);
		chk("rresp", 32'(r), 32'(rresp));
		@(posedge clk);
		rr <= 0;
	endtask
	// Collect discard, acquire and monitor strobes over n cycles
	task automatic watch(input int n, input logic [2:0] e);
		logic [2:0] s;
		s = 0;
		repeat (n) begin
			@(negedge clk);
			s |= {dsc, acq, mon};
		end
		chk("pll", 32'(e), 32'(s));
	endtask
	task automatic step(input logic [2:0] e);
		@(posedge clk) stp <= 1;
		@(posedge clk) stp <= 0;
		watch(5, e);
	endtask
	task automatic invalid;
		@(posedge clk) inv <= 1;
		@(posedge clk) inv <= 0;
		repeat (3) @(negedge clk);
	endtask
	// Pin toggling judged by load edge counts over six cycles
	task automatic pins(input logic [8:0] e);
		logic [7:0] c0 [4];
		logic [8:0] g;
		repeat (6) @(negedge clk);
		for (int i = 0; i < 4; i++) c0[i] = ed[i];
		repeat (6) @(negedge clk);
		for (int i = 0; i < 4; i++)
			g[8 - 2 * i -: 2] = ed[i] != c0[i] ? 2'h2 : {1'h0, lv[i]};
		g[0] = s_oe;
		chk("pins", 32'(e), 32'(g));
	endtask
	initial begin
		repeat (20) @(posedge clk);
		rst <= 0;
		repeat (2) @(posedge clk);
		rd(16'h8808, 8'h00, 2'h0);
		rd(16'h880c, 8'h00, 2'h0);
		rd(16'h8814, 8'h00, 2'h0);
		rd(16'h8844, 8'h00, 2'h0);
		pins(9'h154);
		wr(16'h8800, 8'h01, 2'h2);
		rd(16'h8800, 8'h00, 2'h2);
		wr(16'h8814, 8'hbb, 2'h0);
		rd(16'h8814, 8'hb8, 2'h0);
		wr(16'h8814, 8'h74, 2'h0);
		rd(16'h8814, 8'h34, 2'h0);
		for (k = 0; k < 6; k++) begin
			@(posedge clk) auto <= 3'(5 - k);
			wr(16'h8814, {1'h0, 3'(k), 4'h4}, 2'h0);
			repeat (3) @(negedge clk);
			chk("profile", k, 32'(prof));
		end
		@(posedge clk) auto <= 3'h2;
		for (k = 0; k < 4; k++) begin
			wr(16'h8814, {4'h3, 2'(k), 2'h0}, 2'h0);
			repeat (3) @(negedge clk);
			chk("mode", k == 1 || k == 2 ? 3 : 2, 32'(prof));
		end
		wr(16'h8814, 8'h38, 2'h0);
		invalid;
		chk("holdover", 1, 32'(hold));
		rd(16'h8844, 8'h2a, 2'h0);
		wr(16'h8814, 8'h00, 2'h0);
		wr(16'h8814, 8'h34, 2'h0);
		invalid;
		chk("fallback", 32'h4, {prof, hold});
		wr(16'h8814, 8'h00, 2'h0);
		@(posedge clk) auto <= 3'h6;
		repeat (3) @(negedge clk);
		chk("auto", 6, 32'(prof));
		step(3'h6);
		wr(16'h8814, 8'h80, 2'h0);
		step(3'h5);
		@(posedge clk) rv <= 1;
		watch(4, 3'h2);
		step(3'h7);
		for (k = 0; k < 15; k++) begin
			wr(pa[k], pd[k], 2'h0);
			pins(pe[k]);
		end
		chk("runts", 0, rn[0] + rn[1] + rn[2] + rn[3]);
		end_sim;
	end
endmodule
